// *** core/dtb_readout.sv ***
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Window reads give data only unlocked, unsecured, disarmed, trace enabled.
// - Aligned word window write while disarmed unlocks; contents untouched.
// - Lines are 20 bits, read through a 16-bit window in two portions.
// - Each valid window read advances the read pointer.
// - Arming locks the buffer until a disarmed aligned word window write.
// - Byte or misaligned window access reads zero, pointer unchanged.
// - Window reads while armed or trace disabled read zero, pointer kept.
// - Contents undefined at power-on; other resets keep contents.
// - Full flag set after 64 stored lines; then all 64 lines valid.
// - Full flag cleared by arming write and power-on only.
// - Full flag shows at bit 7 of count and status registers.
// - Six-bit counter gives valid lines, 0 to 63 while not full.
// - Counter rollover sets full; end alignment keeps counting.
// - Count cleared by arming write and power-on; other resets keep it.
// - Reading trace data never changes the counter.
// - Begin alignment: full with counter zero disarms, session ends.
// - Full with nonzero count: newest lines overwrite the oldest.
// - Count register readable anytime; writes ignored.
// - Select field picks state 1, 2, 3 control or match flags.
// - Each sequencer state 1 to 3 has its own control register.
// - Alignment bit clear: trigger at end; set: trigger before data.
// - While secured, trace enable cannot be set and tracing stops.
module dtb_readout (
    input wire logic hclk, // Bus clock, 100 MHz.
    input wire logic hresetn, // Power-on reset, async, active low.
    input wire logic sys_reset, // Other system reset, sync, high.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic hreadyout, // Slave ready, always high.
    output logic hresp, // Response, always OKAY.
    output logic [31:0] hrdata, // Read data.
    input wire logic secured, // Security pin, asynchronous.
    input wire logic trace_valid, // Capture offers a line.
    input wire logic [dtb_pkg::LINE_W-1:0] trace_line, // Offered line.
    input wire logic trigger_hit, // Trigger event pulse.
    input wire logic [dtb_pkg::MATCH_W-1:0] match_flags, // Match flags.
    output logic armed, // Session armed.
    output logic [dtb_pkg::SC_W-1:0] scr_one, // State 1 control.
    output logic [dtb_pkg::SC_W-1:0] scr_two, // State 2 control.
    output logic [dtb_pkg::SC_W-1:0] scr_three // State 3 control.
);

    // ------------------------------------------------------------------
    // Security synchroniser.
    // ------------------------------------------------------------------
    logic sec_meta_q;
    logic sec_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_meta_q <= 1'b1;
            sec_q <= 1'b1;
        end else begin
            sec_meta_q <= secured;
            sec_q <= sec_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Address phase decode.
    // ------------------------------------------------------------------
    logic [dtb_pkg::ADDR_W-1:0] addr_q;
    logic wr_q;
    logic ok_size_q;
    logic act_q;
    logic arm_q;
    logic locked_q;
    logic trace_en_q;
    logic align_q;
    logic triggered_q;
    logic full_q;
    logic [dtb_pkg::SEL_W-1:0] sel_q;
    logic [dtb_pkg::CNT_W-1:0] cnt_q;
    logic [dtb_pkg::PTR_W-1:0] ptr_q;
    logic [dtb_pkg::SC_W-1:0] scr_q [3];
    logic [31:0] rdata_q;
    logic [dtb_pkg::LINE_W-1:0] rd_line;

    wire addr_take = hsel && hready && htrans[1];
    wire rd_take = addr_take && !hwrite;
    wire word_ok = (hsize == dtb_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);
    wire [7:0] idx_a = haddr[dtb_pkg::ADDR_W-1:2];
    wire win_rd = rd_take && (idx_a == dtb_pkg::WINDOW_IDX);
    wire rd_allowed = !locked_q && !sec_q && !arm_q && trace_en_q;
    wire win_rd_ok = win_rd && word_ok && rd_allowed;

    // ------------------------------------------------------------------
    // Data phase write decode.
    // ------------------------------------------------------------------
    wire [7:0] idx_d = addr_q[dtb_pkg::ADDR_W-1:2];
    wire wr_act = act_q && wr_q;
    wire wr_ctrl = wr_act && (idx_d == dtb_pkg::CTRL_IDX);
    wire wr_tcr = wr_act && (idx_d == dtb_pkg::TRACE_CTRL_IDX);
    wire wr_scr = wr_act && (idx_d == dtb_pkg::STATE_CTRL_IDX);
    wire wr_unlock = wr_act && ok_size_q && !arm_q
        && (idx_d == dtb_pkg::WINDOW_IDX);
    wire arm_set = wr_ctrl && hwdata[dtb_pkg::ARM_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= '0;
            wr_q <= 1'b0;
            ok_size_q <= 1'b0;
            act_q <= 1'b0;
        end else if (hready) begin
            addr_q <= haddr[dtb_pkg::ADDR_W-1:0];
            wr_q <= hwrite;
            ok_size_q <= word_ok;
            act_q <= addr_take;
        end
    end

    // ------------------------------------------------------------------
    // Trace capture and session end.
    // ------------------------------------------------------------------
    wire store = arm_q && trace_en_q && !sec_q && trace_valid
        && ((align_q == dtb_pkg::ALIGN_END) || triggered_q);
    wire wrap = store && (cnt_q == dtb_pkg::CNT_LAST);
    wire begin_stop = wrap && (align_q == dtb_pkg::ALIGN_BEGIN);
    wire end_stop = arm_q && trigger_hit && (align_q == dtb_pkg::ALIGN_END);

    dtb_trace_ram u_ram (
        .hclk(hclk),
        .wr_en(store),
        .wr_idx(cnt_q),
        .wr_line(trace_line),
        .rd_idx(ptr_q[dtb_pkg::PTR_W-1:1]),
        .rd_line(rd_line)
    );

    // Counter and full flag survive sys_reset. A store in the same cycle
    // as an arming write wins so that no captured line is forgotten.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= dtb_pkg::CNT_RESET;
            full_q <= 1'b0;
        end else if (store) begin
            cnt_q <= cnt_q + 6'h01;
            full_q <= full_q || wrap;
        end else if (arm_set) begin
            cnt_q <= dtb_pkg::CNT_RESET;
            full_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_q <= 1'b0;
            sel_q <= dtb_pkg::SEL_SCR1;
        end else if (sys_reset || begin_stop || end_stop) begin
            arm_q <= 1'b0;
            sel_q <= sys_reset ? dtb_pkg::SEL_SCR1 : sel_q;
        end else if (wr_ctrl) begin
            arm_q <= hwdata[dtb_pkg::ARM_BIT];
            sel_q <= hwdata[dtb_pkg::SEL_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trace_en_q <= 1'b0;
            align_q <= dtb_pkg::ALIGN_END;
        end else if (sys_reset || sec_q) begin
            trace_en_q <= 1'b0;
            align_q <= sys_reset ? dtb_pkg::ALIGN_END : align_q;
        end else if (wr_tcr && !arm_q) begin
            trace_en_q <= hwdata[dtb_pkg::TRACE_EN_BIT];
            align_q <= hwdata[dtb_pkg::ALIGN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            triggered_q <= 1'b0;
        end else if (arm_set || !arm_q) begin
            triggered_q <= 1'b0;
        end else if (trigger_hit) begin
            triggered_q <= 1'b1;
        end
    end

    genvar s;
    generate
        for (s = 0; s < 3; s++) begin : g_scr
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    scr_q[s] <= dtb_pkg::SC_RESET;
                end else if (sys_reset) begin
                    scr_q[s] <= dtb_pkg::SC_RESET;
                end else if (wr_scr && !arm_q
                    && (sel_q == (dtb_pkg::SEL_W)'(s))) begin
                    scr_q[s] <= hwdata[dtb_pkg::SC_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Buffer lock and read pointer.
    // ------------------------------------------------------------------
    // After unlock the pointer starts at the oldest line: slot 0, or the
    // next write slot once the buffer has wrapped.
    wire [dtb_pkg::CNT_W-1:0] oldest = full_q ? cnt_q : dtb_pkg::CNT_RESET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            locked_q <= 1'b1;
            ptr_q <= dtb_pkg::PTR_RESET;
        end else if (arm_set) begin
            locked_q <= 1'b1;
        end else if (wr_unlock) begin
            locked_q <= 1'b0;
            ptr_q <= {oldest, 1'b0};
        end else if (win_rd_ok) begin
            ptr_q <= ptr_q + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    // Even pointer gives the top bits of a line, odd gives the low 16.
    wire [dtb_pkg::WIN_W-1:0] win_val = ptr_q[0]
        ? rd_line[dtb_pkg::WIN_W-1:0]
        : {{(dtb_pkg::WIN_W-dtb_pkg::HIGH_W){1'b0}},
           rd_line[dtb_pkg::LINE_W-1:dtb_pkg::WIN_W]};
    wire [2:0] ssf = arm_q ? dtb_pkg::SSF_STATE1 : dtb_pkg::SSF_IDLE;
    wire [7:0] ctrl_val = {arm_q, 5'h00, sel_q};
    wire [7:0] stat_val = {full_q, 4'h0, ssf};
    wire [7:0] tcr_val = {1'b0, trace_en_q, 5'h00, align_q};
    wire [7:0] cnt_val = {full_q, 1'b0, cnt_q};
    wire [7:0] scr_val = (sel_q == dtb_pkg::SEL_MATCH)
        ? {4'h0, match_flags} : {4'h0, scr_q[sel_q]};
    wire [31:0] rd_mux =
        (idx_a == dtb_pkg::CTRL_IDX) ? {24'h0, ctrl_val} :
        (idx_a == dtb_pkg::STATUS_IDX) ? {24'h0, stat_val} :
        (idx_a == dtb_pkg::TRACE_CTRL_IDX) ? {24'h0, tcr_val} :
        (idx_a == dtb_pkg::COUNT_IDX) ? {24'h0, cnt_val} :
        (idx_a == dtb_pkg::STATE_CTRL_IDX) ? {24'h0, scr_val} :
        win_rd_ok ? {16'h0, win_val} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign armed = arm_q;
    assign scr_one = scr_q[0];
    assign scr_two = scr_q[1];
    assign scr_three = scr_q[2];

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_ptr_advance: assert property (
        win_rd_ok && !arm_set && !wr_unlock |=> ptr_q == $past(ptr_q) + 7'h01
    ) else $error("Pointer did not advance on a valid window read.");

    a_bad_read_hold: assert property (
        win_rd && !word_ok && !wr_unlock |=> $stable(ptr_q) ##0 hrdata == 32'h0
    ) else $error("Bad window read moved pointer or gave data.");

    a_armed_read_zero: assert property (
        win_rd && (arm_q || !trace_en_q) && !wr_unlock
        |=> hrdata == 32'h0 && $stable(ptr_q)
    ) else $error("Armed or disabled window read gave data.");

    a_arm_locks: assert property (
        arm_set |=> locked_q && arm_q [*1] ##1 (locked_q || !$past(arm_q))
    ) else $error("Arming did not lock the buffer.");

    a_unlock_write: assert property (
        wr_unlock && !arm_set |=> !locked_q && ptr_q[0] == 1'b0
    ) else $error("Disarmed window write did not unlock.");

    a_arm_clears: assert property (
        arm_set && !store |=> cnt_q == 6'h00 && !full_q
    ) else $error("Arming did not clear count and full flag.");

    a_wrap_full: assert property (
        wrap |=> full_q && cnt_q == 6'h00
    ) else $error("Rollover did not set the full flag.");

    a_begin_stop: assert property (
        begin_stop && !wr_ctrl |=> !arm_q
    ) else $error("Begin alignment session did not end when full.");

    a_count_keeps: assert property (
        win_rd_ok && !store && !arm_set |=> $stable(cnt_q) && $stable(full_q)
    ) else $error("Trace read changed the counter.");

    a_secure_trace: assert property (
        sec_q |=> !trace_en_q
    ) else $error("Trace enable held while secured.");

    a_scr_locked: assert property (
        arm_q && !sys_reset |=> $stable(scr_q[0]) && $stable(scr_q[1])
            && $stable(scr_q[2])
    ) else $error("State control changed while armed.");

    a_full_sticky: assert property (
        full_q && !arm_set |=> full_q
    ) else $error("Full flag dropped without an arming write.");

    a_count_ro: assert property (
        !store && !arm_set |=> $stable(cnt_q)
    ) else $error("Count changed without a stored line or arming.");

    a_lock_kept: assert property (
        locked_q && !wr_unlock |=> locked_q
    ) else $error("Buffer unlocked without a disarmed window write.");

    a_full_mirror: assert property (
        rd_take && (idx_a == dtb_pkg::STATUS_IDX
            || idx_a == dtb_pkg::COUNT_IDX)
        |=> hrdata[dtb_pkg::FULL_BIT] == $past(full_q)
    ) else $error("Full flag differs between status and count.");

    a_match_view: assert property (
        rd_take && idx_a == dtb_pkg::STATE_CTRL_IDX
            && sel_q == dtb_pkg::SEL_MATCH
        |=> hrdata == {28'h0, $past(match_flags)}
    ) else $error("Match flags not shown on select three.");

    c_valid_read: cover property (win_rd_ok ##1 win_rd_ok);
    c_full: cover property (wrap && (align_q == dtb_pkg::ALIGN_END));
    c_begin_stop: cover property (begin_stop);
    c_unlock: cover property (wr_unlock ##[1:20] win_rd_ok);
    c_sys_keep: cover property (sys_reset && full_q);

endmodule

// *** core/dtb_pkg.sv ***
package dtb_pkg;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_IDX = 8'h20;
    localparam logic [7:0] STATUS_IDX = 8'h21;
    localparam logic [7:0] TRACE_CTRL_IDX = 8'h22;
    localparam logic [7:0] WINDOW_IDX = 8'h24;
    localparam logic [7:0] COUNT_IDX = 8'h26;
    localparam logic [7:0] STATE_CTRL_IDX = 8'h27;
    localparam int ADDR_W = 10;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int ARM_BIT = 7;
    localparam int FULL_BIT = 7;
    localparam int TRACE_EN_BIT = 6;
    localparam int ALIGN_BIT = 0;
    localparam int SEL_W = 2;
    localparam int SC_W = 4;
    localparam int MATCH_W = 4;

    // ------------------------------------------------------------------
    // Trace storage shape.
    // ------------------------------------------------------------------
    localparam int LINE_W = 20;
    localparam int WIN_W = 16;
    localparam int HIGH_W = LINE_W - WIN_W;
    localparam int DEPTH = 64;
    localparam int CNT_W = 6;
    localparam int PTR_W = CNT_W + 1;

    // ------------------------------------------------------------------
    // Encodings and reset values.
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_SCR1 = 2'h0;
    localparam logic [1:0] SEL_SCR2 = 2'h1;
    localparam logic [1:0] SEL_SCR3 = 2'h2;
    localparam logic [1:0] SEL_MATCH = 2'h3;
    localparam logic [2:0] SSF_IDLE = 3'h0;
    localparam logic [2:0] SSF_STATE1 = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [CNT_W-1:0] CNT_LAST = 6'h3f;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [SC_W-1:0] SC_RESET = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;

    typedef enum logic {
        ALIGN_END,
        ALIGN_BEGIN
    } dtb_align_type;

endpackage

// *** core/dtb_trace_ram.sv ***
`timescale 1ns/1ps
module dtb_trace_ram (
    input wire logic hclk, // Bus clock.
    input wire logic wr_en, // Store one line this cycle.
    input wire logic [dtb_pkg::CNT_W-1:0] wr_idx, // Line written.
    input wire logic [dtb_pkg::LINE_W-1:0] wr_line, // Line data.
    input wire logic [dtb_pkg::CNT_W-1:0] rd_idx, // Line read.
    output logic [dtb_pkg::LINE_W-1:0] rd_line // Line at rd_idx.
);

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    // No reset: contents are undefined after power-on and survive
    // every other reset.
    logic [dtb_pkg::LINE_W-1:0] mem_q [dtb_pkg::DEPTH];

    genvar i;
    generate
        for (i = 0; i < dtb_pkg::DEPTH; i++) begin : g_line
            always_ff @(posedge hclk) begin
                if (wr_en && (wr_idx == (dtb_pkg::CNT_W)'(i))) begin
                    mem_q[i] <= wr_line;
                end
            end
        end
    endgenerate

    assign rd_line = mem_q[rd_idx];

endmodule

// *** sim/dtb_readout_test.sv ***
`timescale 1ns/1ps
module dtb_readout_test;

    // ------------------------------------------------------------------
    // Signals, addresses and the expected trace store.
    // ------------------------------------------------------------------
    localparam logic [31:0] A_CTRL = {22'h0, dtb_pkg::CTRL_IDX, 2'h0};
    localparam logic [31:0] A_STAT = {22'h0, dtb_pkg::STATUS_IDX, 2'h0};
    localparam logic [31:0] A_TCTL = {22'h0, dtb_pkg::TRACE_CTRL_IDX, 2'h0};
    localparam logic [31:0] A_WIN = {22'h0, dtb_pkg::WINDOW_IDX, 2'h0};
    localparam logic [31:0] A_CNT = {22'h0, dtb_pkg::COUNT_IDX, 2'h0};
    localparam logic [31:0] A_SC = {22'h0, dtb_pkg::STATE_CTRL_IDX, 2'h0};
    logic hclk, hresetn, sys_reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic secured, trace_valid, trigger_hit, armed;
    logic [dtb_pkg::LINE_W-1:0] trace_line;
    logic [dtb_pkg::MATCH_W-1:0] match_flags;
    logic [dtb_pkg::SC_W-1:0] scr_one, scr_two, scr_three, sv, mf, so;
    logic [dtb_pkg::LINE_W-1:0] model [dtb_pkg::DEPTH];
    logic [31:0] lfsr, rd;
    int error_cnt, cmp_count, wr_pos;

    // The single slave drives the bus ready line.
    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    dtb_readout u_dtb_readout (.hclk(hclk), .hresetn(hresetn),
        .sys_reset(sys_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .secured(secured), .trace_valid(trace_valid),
        .trace_line(trace_line), .trigger_hit(trigger_hit),
        .match_flags(match_flags), .armed(armed), .scr_one(scr_one),
        .scr_two(scr_two), .scr_three(scr_three));

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Count register image: full flag at bit 7, lines modulo the depth.
    function automatic logic [31:0] cnt_exp(input int lines);
        logic [5:0] n;
        n = 6'(lines % dtb_pkg::DEPTH);
        return {24'h0, (lines >= dtb_pkg::DEPTH), 1'b0, n};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One single transfer; the data phase ends at the second ready edge.
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [2:0] sz, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check("hresp_okay", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, dtb_pkg::HSIZE_WORD, d);
    endtask

    task automatic rchk(input string n, input logic [31:0] a, exp);
        bus(1'b0, a, dtb_pkg::HSIZE_WORD, 32'h0);
        check(n, rd, exp);
    endtask

    // Lines offered before a begin trigger are not expected in store.
    task automatic store(input int n, input bit keep);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            lfsr = lfsr_next(lfsr);
            trace_valid <= 1'b1;
            trace_line <= lfsr[19:0];
            if (keep) begin
                model[wr_pos] = lfsr[19:0];
                wr_pos = (wr_pos + 1) % dtb_pkg::DEPTH;
            end
        end
        @(posedge hclk);
        trace_valid <= 1'b0;
    endtask

    task automatic pulse_trigger();
        @(posedge hclk);
        trigger_hit <= 1'b1;
        @(posedge hclk);
        trigger_hit <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    task automatic walk(input int first, input int n);
        int idx;
        for (int k = 0; k < n; k++) begin
            idx = (first + k) % dtb_pkg::DEPTH;
            rchk("win_high", A_WIN, {28'h0, model[idx][19:16]});
            rchk("win_low", A_WIN, {16'h0, model[idx][15:0]});
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {hresetn, sys_reset, hsel, hwrite, htrans, hsize} = '0;
        {haddr, hwdata, secured, trace_valid, trigger_hit} = '0;
        trace_line = '0;
        match_flags = '0;
        lfsr = 32'h46;
        error_cnt = 0;
        cmp_count = 0;
        wr_pos = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("count_por", A_CNT, 32'h0);
        rchk("status_por", A_STAT, 32'h0);
        rchk("win_por_locked", A_WIN, 32'h0);
        wr(A_TCTL, 32'h40);
        wr(A_CTRL, 32'h80);
        // The arm flop updates on the edge that closes the write.
        @(negedge hclk);
        check("armed_set", {31'h0, armed}, 32'h1);
        rchk("win_armed", A_WIN, 32'h0);
        wr(A_WIN, 32'h0);
        store(70, 1'b1);
        rchk("count_wrap", A_CNT, cnt_exp(70));
        rchk("status_armed_full", A_STAT, 32'h81);
        pulse_trigger();
        check("armed_end", {31'h0, armed}, 32'h0);
        rchk("status_full", A_STAT, 32'h80);
        wr(A_CNT, 32'h0);
        rchk("count_ro", A_CNT, cnt_exp(70));
        rchk("win_locked", A_WIN, 32'h0);
        wr(A_WIN, 32'h0);
        walk(6, 10);
        bus(1'b0, A_WIN, 3'h0, 32'h0);
        check("win_byte", rd, 32'h0);
        bus(1'b0, A_WIN + 32'h2, dtb_pkg::HSIZE_WORD, 32'h0);
        check("win_misaligned", rd, 32'h0);
        wr(A_TCTL, 32'h0);
        rchk("win_trace_off", A_WIN, 32'h0);
        @(posedge hclk);
        secured <= 1'b1;
        repeat (3) @(posedge hclk);
        wr(A_TCTL, 32'h40);
        rchk("trace_en_secured", A_TCTL, 32'h0);
        rchk("win_secured", A_WIN, 32'h0);
        @(posedge hclk);
        secured <= 1'b0;
        repeat (3) @(posedge hclk);
        wr(A_TCTL, 32'h40);
        walk(16, 10);
        @(posedge hclk);
        sys_reset <= 1'b1;
        @(posedge hclk);
        sys_reset <= 1'b0;
        rchk("count_sysrst", A_CNT, cnt_exp(70));
        wr(A_TCTL, 32'h40);
        walk(26, 45);
        rchk("count_after_read", A_CNT, cnt_exp(70));
        lfsr = lfsr_next(lfsr);
        mf = lfsr[3:0];
        @(posedge hclk);
        match_flags <= mf;
        for (int s = 0; s < 4; s++) begin
            lfsr = lfsr_next(lfsr);
            sv = (s < 3) ? lfsr[3:0] : mf;
            wr(A_CTRL, s);
            wr(A_SC, {28'h0, lfsr[3:0]});
            rchk("state_ctrl", A_SC, {28'h0, sv});
            so = (s == 0) ? scr_one : (s == 1) ? scr_two : scr_three;
            if (s < 3) begin
                check("scr_out", {28'h0, so}, {28'h0, sv});
            end
        end
        rchk("unmapped", 32'hfc, 32'h0);
        wr(A_TCTL, 32'h41);
        wr(A_CTRL, 32'h80);
        wr_pos = 0;
        rchk("count_rearm", A_CNT, 32'h0);
        store(3, 1'b0);
        pulse_trigger();
        store(64, 1'b1);
        repeat (2) @(posedge hclk);
        check("armed_begin", {31'h0, armed}, 32'h0);
        rchk("count_begin", A_CNT, cnt_exp(64));
        wr(A_WIN, 32'h0);
        walk(0, 2);
        give_verdict();
    end

    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end

endmodule
